// ==== inc/rcd_pkg.sv ====
// shared constants for the reset cause and debug reset block
package rcd_pkg;
	localparam logic [7:0] STATUS_POR_RESET = 8'h82;
	localparam logic [7:0] STATUS_LVR_RESET = 8'h02;
	localparam logic [7:0] FORCE_READ_VALUE = 8'h00;
	localparam int BIT_POWER_ON = 7;
	localparam int BIT_PIN = 6;
	localparam int BIT_WATCHDOG = 5;
	localparam int BIT_ILLEGAL_OPCODE = 4;
	localparam int BIT_ILLEGAL_ADDRESS = 3;
	localparam int BIT_LOW_VOLTAGE = 1;
	localparam int BIT_FORCE_RESET = 0;
	localparam int WATCHDOG_BITS = 16;
	localparam logic [15:0] WATCHDOG_LIMIT = 16'hffff;
	localparam int HOLD_TIME_NS = 100;
	localparam int CLOCK_PERIOD_NS = 5;
	localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	typedef enum logic [1:0] {
		RCD_RUN,
		RCD_ENTRY,
		RCD_HOLD
	} rcd_state_e;
endpackage

// ==== rtl/rcd_sync.sv ====
// two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module rcd_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			stage1_q <= '0;
			sync_o <= '0;
		end else begin
			stage1_q <= async_i;
			sync_o <= stage1_q;
		end
	end
endmodule

// ==== rtl/rcd_top.sv ====
// reset cause status, watchdog service and debug forced reset
`timescale 1ns/1ps
//
// Contract
// - status register shows cause of last reset; software writes never alter it
// - debug forced reset clears every cause flag
// - any write to status address restarts watchdog, flags unchanged
// - other resets set flags of active sources, clear others; low-voltage reset sets only its own flag
// - power-on sets bit 7 and also the low-voltage flag
// - bit 6 set when reset came from low external reset pin
// - bit 5 set on watchdog timeout; blocked when watchdog disabled
// - bit 4 set when illegal opcode caused reset
// - stop illegal without stop enable; background illegal without debug enable
// - bit 3 set on access to unimplemented address
// - low supply with low-voltage reset enabled resets and sets bit 1
// - user program writes to force reset register are ignored
// - force reset register always reads zero
// - debug host writes 1 to force bit; device does full reset
// - bits 2 and 0 of status always read zero
// - stop with stop enable 0 forces illegal-opcode reset
module rcd_top (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic power_on_i,
	input wire logic low_voltage_i,
	input wire logic low_voltage_reset_enable_i,
	input wire logic reset_pin_n_i,
	input wire logic watchdog_enable_i,
	input wire logic illegal_opcode_i,
	input wire logic stop_exec_i,
	input wire logic stop_enable_i,
	input wire logic background_exec_i,
	input wire logic debug_mode_enable_i,
	input wire logic illegal_address_i,
	input wire logic status_wr_i,
	input wire logic status_rd_i,
	input wire logic force_wr_i,
	input wire logic force_rd_i,
	input wire logic force_from_debug_i,
	input wire logic [7:0] wr_data_i,
	input wire logic mode_select_pin_i,
	output logic [7:0] rd_data_o,
	output logic mcu_reset_o,
	output logic background_debug_mode_o,
	output logic watchdog_timeout_o
);
	logic pin_low_sync;
	logic low_voltage_sync;
	logic mode_pin_sync;
	logic [4:0] status_q;
	logic [4:0] status_d;
	rcd_pkg::rcd_state_e state_q;
	logic [7:0] hold_q;
	logic [15:0] watchdog_q;
	logic forced_q;
	logic power_on_q;
	logic lvr_q;
	logic illegal_op_src;
	logic watchdog_src;
	logic lvr_src;
	logic force_req;
	logic any_src;
	logic [7:0] rd_d;
	logic [7:0] status_view;

	////////////////////////////////////////////////////////////////
	// helpers shared by the watchdog, the sequencer and the mode sampling
	function automatic logic at_limit(input logic [15:0] count);
		return count == rcd_pkg::WATCHDOG_LIMIT;
	endfunction

	// release waits for the minimum hold and for every level source to drop
	function automatic logic hold_over(input logic [7:0] count, input logic pin_low,
		input logic low_voltage_reset);
		return count >= 8'(rcd_pkg::HOLD_CYCLES) && !pin_low && !low_voltage_reset;
	endfunction

	////////////////////////////////////////////////////////////////
	// pin inputs cross into the bus clock through two flops
	rcd_sync #(
		.WIDTH(3)
	) u_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.async_i({~reset_pin_n_i, low_voltage_i, mode_select_pin_i}),
		.sync_o({pin_low_sync, low_voltage_sync, mode_pin_sync})
	);

	////////////////////////////////////////////////////////////////
	// reset sources
	// stop and background decode come from cpu logic on this clock
	assign illegal_op_src = illegal_opcode_i
		| (stop_exec_i & ~stop_enable_i)
		| (background_exec_i & ~debug_mode_enable_i);
	assign watchdog_src = watchdog_enable_i & at_limit(watchdog_q);
	assign lvr_src = low_voltage_reset_enable_i & low_voltage_sync;
	// only the serial debug path may force a reset
	assign force_req = force_wr_i & force_from_debug_i
		& wr_data_i[rcd_pkg::BIT_FORCE_RESET];
	assign any_src = illegal_op_src | watchdog_src | lvr_src | force_req
		| pin_low_sync | illegal_address_i;
	assign watchdog_timeout_o = watchdog_src;

	////////////////////////////////////////////////////////////////
	// watchdog counter, restarted by any write to the status address
	always_ff @(posedge clock_i) begin
		if (rst_i || state_q != rcd_pkg::RCD_RUN) begin
			watchdog_q <= '0;
		end else if (status_wr_i) begin
			watchdog_q <= '0;
		end else if (watchdog_enable_i && !at_limit(watchdog_q)) begin
			// the count saturates, so the timeout stands until the sequencer takes it
			watchdog_q <= watchdog_q + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// shared reset sequencer: entry, then a minimum hold
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= rcd_pkg::RCD_HOLD;
			hold_q <= '0;
		end else begin
			unique case (state_q)
				rcd_pkg::RCD_RUN: begin
					// power-on restarts the core as well as setting its flags
					if (any_src || power_on_i) begin
						state_q <= rcd_pkg::RCD_ENTRY;
					end
				end
				rcd_pkg::RCD_ENTRY: begin
					state_q <= rcd_pkg::RCD_HOLD;
					hold_q <= '0;
				end
				rcd_pkg::RCD_HOLD: begin
					// a pin or low-voltage source still held keeps the device in reset
					if (hold_q < 8'(rcd_pkg::HOLD_CYCLES)) begin
						hold_q <= hold_q + 8'h01;
					end else if (hold_over(hold_q, pin_low_sync, lvr_src)) begin
						state_q <= rcd_pkg::RCD_RUN;
					end
				end
			endcase
		end
	end

	// decoded straight from the state register; no source feeds it directly
	assign mcu_reset_o = (state_q != rcd_pkg::RCD_RUN);

	////////////////////////////////////////////////////////////////
	// cause capture at reset entry
	// packed cause bits, high to low: pin, watchdog, illegal opcode, illegal address
	always_comb begin
		status_d = '0;
		status_d[3] = pin_low_sync;
		status_d[2] = watchdog_src;
		status_d[1] = illegal_op_src;
		status_d[0] = illegal_address_i;
		if (force_req) begin
			status_d = '0;
		end
	end

	// power-on enters through rst_i or power_on_i; either one sets power_on_q and lvr_q
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			status_q <= '0;
			forced_q <= 1'b0;
			power_on_q <= 1'b1;
			lvr_q <= 1'b1;
		end else if (power_on_i) begin
			status_q <= '0;
			power_on_q <= 1'b1;
			lvr_q <= 1'b1;
			forced_q <= 1'b0;
		end else if (state_q == rcd_pkg::RCD_RUN && any_src) begin
			// low-voltage reset reports only its own flag
			if (lvr_src && !force_req) begin
				status_q <= '0;
				lvr_q <= 1'b1;
			end else begin
				status_q <= status_d;
				lvr_q <= 1'b0;
			end
			power_on_q <= 1'b0;
			forced_q <= force_req;
		end
		// writes to the status address never touch these flags
	end

	////////////////////////////////////////////////////////////////
	// mode selection sampled from the mode pin as a forced reset ends
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			background_debug_mode_o <= 1'b0;
		end else if (state_q == rcd_pkg::RCD_HOLD && hold_over(hold_q, pin_low_sync, lvr_src)) begin
			background_debug_mode_o <= forced_q & ~mode_pin_sync;
		end
	end

	////////////////////////////////////////////////////////////////
	// read data
	always_comb begin
		status_view = '0;
		status_view[rcd_pkg::BIT_POWER_ON] = power_on_q;
		status_view[rcd_pkg::BIT_PIN] = status_q[3];
		status_view[rcd_pkg::BIT_WATCHDOG] = status_q[2];
		status_view[rcd_pkg::BIT_ILLEGAL_OPCODE] = status_q[1];
		status_view[rcd_pkg::BIT_ILLEGAL_ADDRESS] = status_q[0];
		status_view[rcd_pkg::BIT_LOW_VOLTAGE] = lvr_q;
		rd_d = '0;
		if (status_rd_i) begin
			rd_d = status_view;
		end else if (force_rd_i) begin
			rd_d = rcd_pkg::FORCE_READ_VALUE;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	sequence s_force_write;
		state_q == rcd_pkg::RCD_RUN && force_req;
	endsequence

	// an entry whose flags follow the per-source capture
	sequence s_plain_entry;
		state_q == rcd_pkg::RCD_RUN && !force_req && !lvr_src && !power_on_i;
	endsequence

	// the last hold cycle followed by the first running cycle
	sequence s_hold_exit;
		state_q == rcd_pkg::RCD_HOLD ##1 state_q == rcd_pkg::RCD_RUN;
	endsequence

	// forced reset, register access and flag behaviour
	chk_force_clears: assert property (@(posedge clock_i) disable iff (rst_i)
		s_force_write and !power_on_i |=> status_q == '0 && !power_on_q)
		else $error("forced reset left a cause flag set");
	chk_force_enters: assert property (@(posedge clock_i) disable iff (rst_i)
		s_force_write |=> mcu_reset_o [*2])
		else $error("forced reset did not enter the sequencer");
	chk_user_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
		force_wr_i && !force_from_debug_i && !any_src && state_q == rcd_pkg::RCD_RUN && !power_on_i
		|=> !mcu_reset_o)
		else $error("user write to force register caused reset");
	chk_force_reads: assert property (@(posedge clock_i) disable iff (rst_i)
		force_rd_i && !status_rd_i |=> rd_data_o == 8'h00)
		else $error("force register read nonzero");
	chk_unused_zero: assert property (@(posedge clock_i) disable iff (rst_i)
		status_rd_i |=> rd_data_o[2] == 1'b0 && rd_data_o[0] == 1'b0)
		else $error("unused status bits read nonzero");
	chk_status_write: assert property (@(posedge clock_i) disable iff (rst_i)
		status_wr_i && !power_on_i && !(state_q == rcd_pkg::RCD_RUN && any_src)
		|=> $stable(status_q) && $stable(lvr_q) && watchdog_q == '0)
		else $error("status write altered flags or missed watchdog restart");
	chk_power_on: assert property (@(posedge clock_i) disable iff (rst_i)
		power_on_i |=> power_on_q && lvr_q)
		else $error("power-on flags not both set");
	chk_stop_illegal: assert property (@(posedge clock_i) disable iff (rst_i)
		state_q == rcd_pkg::RCD_RUN && stop_exec_i && !stop_enable_i && !force_req
		&& !lvr_src && !power_on_i |=> status_q[1] && mcu_reset_o)
		else $error("disabled stop did not cause illegal opcode reset");
	chk_watchdog_block: assert property (@(posedge clock_i) disable iff (rst_i)
		!watchdog_enable_i |-> !watchdog_timeout_o)
		else $error("watchdog reset while disabled");
	chk_flags_held: assert property (@(posedge clock_i) disable iff (rst_i)
		state_q == rcd_pkg::RCD_RUN && !any_src && !power_on_i |=> $stable(status_q))
		else $error("cause flags changed outside reset entry");
	chk_hold_keeps: assert property (@(posedge clock_i) disable iff (rst_i)
		state_q != rcd_pkg::RCD_RUN && !power_on_i
		|=> $stable(status_q) && $stable(lvr_q) && $stable(power_on_q))
		else $error("cause flags changed while held in reset");

	// per-source capture, leaving out entries that a force or a low supply overrides; then the low-supply entry itself
	chk_stale_cleared: assert property (@(posedge clock_i) disable iff (rst_i)
		s_plain_entry and (any_src && !pin_low_sync) |=> !status_q[3])
		else $error("inactive pin source left its flag set");
	chk_pin_flag: assert property (@(posedge clock_i) disable iff (rst_i)
		s_plain_entry and pin_low_sync |=> status_q[3] && mcu_reset_o)
		else $error("pin reset not flagged");
	chk_watchdog_flag: assert property (@(posedge clock_i) disable iff (rst_i)
		s_plain_entry and watchdog_src |=> status_q[2] && !power_on_q && !lvr_q)
		else $error("watchdog reset not flagged");
	chk_opcode_flag: assert property (@(posedge clock_i) disable iff (rst_i)
		s_plain_entry and illegal_opcode_i |=> status_q[1] && mcu_reset_o)
		else $error("illegal opcode reset not flagged");
	chk_background_instruction_illegal: assert property (@(posedge clock_i) disable iff (rst_i)
		s_plain_entry and (background_exec_i && !debug_mode_enable_i)
		|=> status_q[1] && mcu_reset_o)
		else $error("disabled background instruction did not reset");
	chk_address_flag: assert property (@(posedge clock_i) disable iff (rst_i)
		s_plain_entry and illegal_address_i |=> status_q[0] && mcu_reset_o)
		else $error("illegal address reset not flagged");
	chk_lvr_only: assert property (@(posedge clock_i) disable iff (rst_i)
		state_q == rcd_pkg::RCD_RUN && lvr_src && !force_req && !power_on_i
		|=> status_q == '0 && lvr_q && !power_on_q)
		else $error("low-voltage reset flags wrong");

	// sequencer and watchdog behaviour
	chk_power_enters: assert property (@(posedge clock_i) disable iff (rst_i)
		state_q == rcd_pkg::RCD_RUN && power_on_i |=> mcu_reset_o [*2])
		else $error("power-on did not enter the sequencer");
	chk_level_holds: assert property (@(posedge clock_i) disable iff (rst_i)
		state_q == rcd_pkg::RCD_HOLD && (pin_low_sync || lvr_src) |=> mcu_reset_o)
		else $error("reset released while a level source was active");
	chk_hold_length: assert property (@(posedge clock_i) disable iff (rst_i)
		s_hold_exit |-> hold_q == 8'(rcd_pkg::HOLD_CYCLES))
		else $error("reset released before the minimum hold");
	chk_run_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
		state_q == rcd_pkg::RCD_RUN && !any_src && !power_on_i |=> !mcu_reset_o)
		else $error("reset entered with no source active");
	chk_force_full: assert property (@(posedge clock_i) disable iff (rst_i)
		s_force_write |=> mcu_reset_o ##1 watchdog_q == '0)
		else $error("forced reset did not restart the core");
	chk_watchdog_frozen: assert property (@(posedge clock_i) disable iff (rst_i)
		!watchdog_enable_i && !status_wr_i && state_q == rcd_pkg::RCD_RUN
		|=> watchdog_q == $past(watchdog_q))
		else $error("disabled watchdog kept counting");
	chk_stop_legal: assert property (@(posedge clock_i) disable iff (rst_i)
		state_q == rcd_pkg::RCD_RUN && stop_exec_i && stop_enable_i && !illegal_opcode_i
		&& !background_exec_i && !illegal_address_i && !pin_low_sync && !lvr_src
		&& !watchdog_src && !force_wr_i && !power_on_i |=> !mcu_reset_o)
		else $error("enabled stop caused a reset");

	// read side and mode selection
	chk_status_read: assert property (@(posedge clock_i) disable iff (rst_i)
		status_rd_i |=> rd_data_o[rcd_pkg::BIT_POWER_ON] == $past(power_on_q)
		&& rd_data_o[rcd_pkg::BIT_LOW_VOLTAGE] == $past(lvr_q))
		else $error("status read did not show the held flags");
	chk_mode_select: assert property (@(posedge clock_i) disable iff (rst_i)
		s_hold_exit |-> background_debug_mode_o == $past(forced_q && !mode_pin_sync))
		else $error("mode not taken from the mode pin at reset exit");
endmodule

// ==== verif/rcd_host_model.sv ====
// debug host model: forced reset over the background link, then mode pin
`timescale 1ns/1ps
module rcd_host_model (
	input wire logic clock_i,
	input wire logic go_i,
	input wire logic user_mode_i,
	output logic force_wr_o,
	output logic from_debug_o,
	output logic [7:0] force_data_o,
	output logic mode_pin_o
);
	initial begin
		force_wr_o = 1'b0;
		from_debug_o = 1'b0;
		force_data_o = 8'hfe;
		mode_pin_o = 1'b1;
	end
	// the pin has a pull-up, so an idle host leaves it high
	always @(posedge go_i) begin
		@(negedge clock_i);
		force_wr_o = 1'b1;
		from_debug_o = 1'b1;
		force_data_o = 8'h01;
		@(negedge clock_i);
		force_wr_o = 1'b0;
		from_debug_o = 1'b0;
		force_data_o = 8'hfe;
		mode_pin_o = user_mode_i;
		@(negedge go_i);
		mode_pin_o = 1'b1;
	end
endmodule

// ==== verif/rcd_top_tb.sv ====
// self-checking bench for the reset cause and debug reset block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module rcd_top_tb;
	logic clock_i, rst_i, power_on_i, low_voltage_i, low_voltage_reset_enable_i;
	logic reset_pin_n_i, watchdog_enable_i, illegal_opcode_i, stop_exec_i, stop_enable_i;
	logic background_exec_i, debug_mode_enable_i, illegal_address_i, status_wr_i;
	logic status_rd_i, tb_force_wr, force_rd_i, go, user_mode, h_wr, h_dbg, mode_pin;
	logic [7:0] tb_data, h_data, rd_data_o;
	logic mcu_reset_o, background_debug_mode_o, watchdog_timeout_o, wd_seen;
	int mismatches = 0;
	int checks = 0;
	rcd_host_model host (.clock_i, .go_i(go), .user_mode_i(user_mode), .force_wr_o(h_wr),
		.from_debug_o(h_dbg), .force_data_o(h_data), .mode_pin_o(mode_pin));
	rcd_top dut (.clock_i, .rst_i, .power_on_i, .low_voltage_i, .low_voltage_reset_enable_i,
		.reset_pin_n_i, .watchdog_enable_i, .illegal_opcode_i, .stop_exec_i, .stop_enable_i,
		.background_exec_i, .debug_mode_enable_i, .illegal_address_i, .status_wr_i,
		.status_rd_i, .force_wr_i(tb_force_wr | h_wr), .force_rd_i, .force_from_debug_i(h_dbg),
		.wr_data_i(h_wr ? h_data : tb_data), .mode_select_pin_i(mode_pin), .rd_data_o,
		.mcu_reset_o, .background_debug_mode_o, .watchdog_timeout_o);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (rst_i) wd_seen <= 1'b0;
		else if (watchdog_timeout_o) wd_seen <= 1'b1;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clock_i);
		s = 1'b1;
		@(negedge clock_i);
		s = 1'b0;
	endtask
	// read data stands one cycle, so it is sampled at the negedge after the strobe
	task automatic rd(ref logic s, input logic [7:0] exp, input string nm);
		pulse(s);
		`CHK(nm, exp, rd_data_o)
		$display("test %s done", nm);
	endtask
	task automatic cycle_reset(input logic [7:0] exp, input string nm, input int lim);
		int n;
		n = 0;
		while (mcu_reset_o !== 1'b1 && n < lim) begin
			@(negedge clock_i);
			n++;
		end
		`CHK({nm, " entry"}, 1'b1, mcu_reset_o)
		n = 0;
		while (mcu_reset_o !== 1'b0 && n < 100) begin
			@(negedge clock_i);
			n++;
		end
		`CHK({nm, " exit"}, 1'b0, mcu_reset_o)
		rd(status_rd_i, exp, nm);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#700us;
		mismatches++;
		give_verdict();
	end
	initial begin
		{power_on_i, low_voltage_i, low_voltage_reset_enable_i, watchdog_enable_i} = 4'h0;
		{illegal_opcode_i, stop_exec_i, stop_enable_i, background_exec_i} = 4'h0;
		{debug_mode_enable_i, illegal_address_i, status_wr_i, status_rd_i} = 4'h0;
		{tb_force_wr, force_rd_i, go, user_mode} = 4'h0;
		rst_i = 1'b1;
		reset_pin_n_i = 1'b1;
		tb_data = 8'h00;
		repeat (2) @(negedge clock_i);
		rst_i = 1'b0;
		cycle_reset(8'h82, "por", 40);
		rd(force_rd_i, 8'h00, "force read");
		tb_data = 8'hff;
		pulse(status_wr_i);
		rd(status_rd_i, 8'h82, "status write");
		tb_data = 8'h01;
		pulse(tb_force_wr);
		repeat (5) @(negedge clock_i);
		`CHK("user force", 1'b0, mcu_reset_o)
		rd(status_rd_i, 8'h82, "user force");
		pulse(illegal_opcode_i);
		cycle_reset(8'h10, "illegal_opcode_flag", 40);
		pulse(illegal_address_i);
		cycle_reset(8'h08, "illegal_address_flag", 40);
		stop_enable_i = 1'b1;
		debug_mode_enable_i = 1'b1;
		pulse(stop_exec_i);
		pulse(background_exec_i);
		repeat (5) @(negedge clock_i);
		`CHK("legal stop", 1'b0, mcu_reset_o)
		stop_enable_i = 1'b0;
		pulse(stop_exec_i);
		cycle_reset(8'h10, "stop", 40);
		debug_mode_enable_i = 1'b0;
		pulse(background_exec_i);
		cycle_reset(8'h10, "background_instruction", 40);
		reset_pin_n_i = 1'b0;
		repeat (5) @(negedge clock_i);
		reset_pin_n_i = 1'b1;
		cycle_reset(8'h40, "pin", 40);
		low_voltage_i = 1'b1;
		repeat (10) @(negedge clock_i);
		`CHK("lv off", 1'b0, mcu_reset_o)
		low_voltage_reset_enable_i = 1'b1;
		repeat (5) @(negedge clock_i);
		low_voltage_i = 1'b0;
		cycle_reset(8'h02, "lvr", 40);
		pulse(power_on_i);
		cycle_reset(8'h82, "power on", 40);
		pulse(status_wr_i);
		watchdog_enable_i = 1'b1;
		repeat (30000) @(negedge clock_i);
		pulse(status_wr_i);
		repeat (40000) @(negedge clock_i);
		`CHK("wd restart", 1'b0, mcu_reset_o)
		`CHK("wd early", 1'b0, wd_seen)
		cycle_reset(8'h20, "watchdog", 30000);
		`CHK("wd timeout", 1'b1, wd_seen)
		watchdog_enable_i = 1'b0;
		user_mode = 1'b1;
		go = 1'b1;
		cycle_reset(8'h00, "force user", 40);
		`CHK("user mode", 1'b0, background_debug_mode_o)
		go = 1'b0;
		user_mode = 1'b0;
		@(negedge clock_i);
		go = 1'b1;
		cycle_reset(8'h00, "force debug", 40);
		`CHK("debug mode", 1'b1, background_debug_mode_o)
		go = 1'b0;
		rd(force_rd_i, 8'h00, "force read again");
		give_verdict();
	end
endmodule
